// *** verilog/mdlos_top.v ***
// mdio management slave with per-channel power down and signal loss
`timescale 1ns/1ps
`default_nettype none
`include "mdlos_defs.vh"

module mdlos_top #(
   parameter [15:0] EXT_DEPTH = 16'h0004,
   parameter integer EXT_AW = 2
) (
   // clock and reset
   input wire clk,
   input wire resetn,
   // management link
   input wire mdc,
   input wire mdio_in,
   output wire mdio_out,
   output wire mdio_oe,
   input wire [4:1] port_addr_straps,
   // power-down pins
   input wire chan_a_powerdown_n,
   input wire chan_b_powerdown_n,
   // channel a status sources
   input wire a_raw_los,
   input wire a_sync_lost,
   input wire a_ls_pll_unlock,
   input wire a_hs_pll_unlock,
   input wire a_decode_err,
   input wire a_gain_ctrl_locked,
   input wire a_autozero_cal_done,
   // channel b status sources
   input wire b_raw_los,
   input wire b_sync_lost,
   input wire b_ls_pll_unlock,
   input wire b_hs_pll_unlock,
   input wire b_decode_err,
   input wire b_gain_ctrl_locked,
   input wire b_autozero_cal_done,
   // signal loss outputs
   output wire chan_a_signal_loss_out,
   output wire chan_b_signal_loss_out,
   // per channel controls, bit 0 channel a, bit 1 channel b
   output wire [1:0] powered_down,
   output wire [1:0] ls_tx_hiz,
   output wire [1:0] hs_tx_hiz,
   output wire [1:0] rx_eq_en,
   output wire [3:0] deemph_pre_a,
   output wire [4:0] deemph_post_a,
   output wire [3:0] deemph_pre_b,
   output wire [4:0] deemph_post_b
);

   // ----------------------------------------------------------------
   // frame states
   // ----------------------------------------------------------------
   localparam [2:0] S_PRE = 3'h0;
   localparam [2:0] S_ST = 3'h1;
   localparam [2:0] S_HDR = 3'h2;
   localparam [2:0] S_TA = 3'h3;
   localparam [2:0] S_DAT = 3'h4;

   // ----------------------------------------------------------------
   // input synchronisers
   // ----------------------------------------------------------------
   wire [21:0] sync_w;
   wire [6:0] src_a;
   wire [6:0] src_b;
   wire mdc_s;
   wire bit_s;
   wire [4:1] straps_s;
   wire [1:0] pd_pin_s;

   mdlos_sync #(
      .WIDTH(22)
   ) u_sync (
      .clk(clk),
      .resetn(resetn),
      .async_in({~chan_b_powerdown_n, ~chan_a_powerdown_n,
                 port_addr_straps, mdc, mdio_in,
                 b_autozero_cal_done, b_gain_ctrl_locked, b_decode_err,
                 b_hs_pll_unlock, b_ls_pll_unlock, b_sync_lost, b_raw_los,
                 a_autozero_cal_done, a_gain_ctrl_locked, a_decode_err,
                 a_hs_pll_unlock, a_ls_pll_unlock, a_sync_lost,
                 a_raw_los}),
      .sync_out(sync_w)
   );

   assign src_a = sync_w[6:0];
   assign src_b = sync_w[13:7];
   assign bit_s = sync_w[14];
   assign mdc_s = sync_w[15];
   assign straps_s = sync_w[19:16];
   assign pd_pin_s = sync_w[21:20];

   // ----------------------------------------------------------------
   // signal loss combination
   // ----------------------------------------------------------------
   // src order: autozero, gain, decode, hs pll, ls pll, sync, raw
   function los_fn;
      input [4:0] en;
      input [6:0] src;
      begin
         los_fn = src[0]
            | (en[`MDLOS_EN_SYNC] & src[1])
            | (en[`MDLOS_EN_PLL] & (src[2] | src[3]))
            | (en[`MDLOS_EN_DEC] & src[4])
            | (en[`MDLOS_EN_AGC] & ~src[5])
            | (en[`MDLOS_EN_AZD] & ~src[6]);
      end
   endfunction

   // ----------------------------------------------------------------
   // registers and state
   // ----------------------------------------------------------------
   reg mdc_d_ff;
   reg [2:0] st_ff;
   reg [5:0] cnt_ff;
   reg [11:0] hdr_ff;
   reg [15:0] sh_ff;
   reg rd_ff;
   reg hit_ff;
   reg mdio_out_ff;
   reg mdio_oe_ff;
   reg pd_reg_ff [0:1];
   reg eq_ff [0:1];
   reg [3:0] pre_ff [0:1];
   reg [4:0] post_ff [0:1];
   reg [4:0] losen_ff [0:1];
   reg [15:0] ptr_ff;
   reg [15:0] ext_ff [0:EXT_DEPTH-1];
   reg [1:0] los_ff;
   reg [1:0] pd_ff;
   reg [1:0] eq_out_ff;
   reg [3:0] pre_a_ff;
   reg [4:0] post_a_ff;
   reg [3:0] pre_b_ff;
   reg [4:0] post_b_ff;
   integer i;

   wire rise;
   wire [11:0] hdr_nxt;
   wire [15:0] ext_off;
   wire ext_hit;
   wire [EXT_AW-1:0] ext_idx;
   wire wr_go;
   wire [15:0] wr_data;
   wire wr_chan;
   wire [4:0] wr_reg;
   wire [1:0] pd_now;
   reg [15:0] rd_val;

   assign rise = mdc_s & ~mdc_d_ff;
   assign hdr_nxt = {hdr_ff[10:0], bit_s};
   assign ext_off = ptr_ff - `MDLOS_EXT_BASE;
   assign ext_hit = (ptr_ff >= `MDLOS_EXT_BASE) &&
                    (ext_off < EXT_DEPTH);
   assign ext_idx = ext_off[EXT_AW-1:0];
   assign wr_chan = hdr_ff[5];
   assign wr_reg = hdr_ff[4:0];
   assign wr_data = {sh_ff[14:0], bit_s};
   assign wr_go = rise && st_ff == S_DAT && cnt_ff == 6'h0f &&
                  !rd_ff && hit_ff;
   // pins inverted ahead of sync so a cleared sync reads powered up
   assign pd_now = pd_pin_s | {pd_reg_ff[1], pd_reg_ff[0]};

   // ----------------------------------------------------------------
   // read data selection
   // ----------------------------------------------------------------
   // chosen while the header completes; channel from address lsb
   always @*
   begin
      rd_val = 16'h0000;
      case (hdr_nxt[4:0])
         `MDLOS_REG_CTL1:
            rd_val[`MDLOS_CTL1_PD_BIT] = pd_reg_ff[hdr_nxt[5]];
         `MDLOS_REG_EQ:
            rd_val[`MDLOS_EQ_EN_BIT] = eq_ff[hdr_nxt[5]];
         `MDLOS_REG_DEEMPH:
         begin
            rd_val[`MDLOS_PRE_MSB:`MDLOS_PRE_LSB] = pre_ff[hdr_nxt[5]];
            rd_val[`MDLOS_POST_MSB:`MDLOS_POST_LSB] =
               post_ff[hdr_nxt[5]];
         end
         `MDLOS_REG_LOSEN:
            rd_val[`MDLOS_LOSEN_MSB:0] = losen_ff[hdr_nxt[5]];
         `MDLOS_REG_STAT:
            // may be stale while the channel clocks are stopped
            rd_val[7:0] = hdr_nxt[5] ? {pd_ff[1], src_b} :
                                       {pd_ff[0], src_a};
         `MDLOS_REG_IND_ADDR:
            rd_val = ptr_ff;
         `MDLOS_REG_IND_DATA:
            if (ext_hit)
            begin
               rd_val = ext_ff[ext_idx];
            end
         default:
            rd_val = 16'h0000;
      endcase
   end

   // ----------------------------------------------------------------
   // frame engine
   // ----------------------------------------------------------------
   // runs on sampled mdc, independent of any power-down state
   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         mdc_d_ff <= 1'b0;
         st_ff <= S_PRE;
         cnt_ff <= 6'h00;
         hdr_ff <= 12'h000;
         sh_ff <= 16'h0000;
         rd_ff <= 1'b0;
         hit_ff <= 1'b0;
         mdio_out_ff <= 1'b0;
         mdio_oe_ff <= 1'b0;
      end
      else
      begin
         mdc_d_ff <= mdc_s;
         if (rise)
         begin
            case (st_ff)
               S_PRE:
                  if (bit_s)
                  begin
                     if (cnt_ff != `MDLOS_PRE_BITS)
                     begin
                        cnt_ff <= cnt_ff + 6'h01;
                     end
                  end
                  else if (cnt_ff == `MDLOS_PRE_BITS)
                  begin
                     st_ff <= S_ST;
                     cnt_ff <= 6'h00;
                  end
                  else
                  begin
                     cnt_ff <= 6'h00;
                  end
               S_ST:
                  st_ff <= bit_s ? S_HDR : S_PRE;
               S_HDR:
               begin
                  hdr_ff <= hdr_nxt;
                  cnt_ff <= cnt_ff + 6'h01;
                  if (cnt_ff == 6'h0b)
                  begin
                     st_ff <= S_TA;
                     cnt_ff <= 6'h00;
                     rd_ff <= hdr_nxt[11:10] == `MDLOS_OP_READ;
                     hit_ff <= (hdr_nxt[9:6] == straps_s) &&
                        (hdr_nxt[11:10] == `MDLOS_OP_READ ||
                         hdr_nxt[11:10] == `MDLOS_OP_WRITE);
                     sh_ff <= rd_val;
                  end
               end
               S_TA:
               begin
                  cnt_ff <= cnt_ff + 6'h01;
                  if (cnt_ff == 6'h00)
                  begin
                     // second turnaround bit is a driven zero
                     mdio_oe_ff <= rd_ff & hit_ff;
                     mdio_out_ff <= 1'b0;
                  end
                  else
                  begin
                     st_ff <= S_DAT;
                     cnt_ff <= 6'h00;
                     mdio_out_ff <= rd_ff & hit_ff & sh_ff[15];
                     sh_ff <= {sh_ff[14:0], 1'b0};
                  end
               end
               S_DAT:
               begin
                  cnt_ff <= cnt_ff + 6'h01;
                  sh_ff <= {sh_ff[14:0], bit_s};
                  if (cnt_ff == 6'h0f)
                  begin
                     // new preamble needed before the next frame
                     st_ff <= S_PRE;
                     cnt_ff <= 6'h00;
                     mdio_oe_ff <= 1'b0;
                     mdio_out_ff <= 1'b0;
                  end
                  else
                  begin
                     mdio_out_ff <= rd_ff & hit_ff & sh_ff[15];
                  end
               end
               default:
               begin
                  st_ff <= S_PRE;
                  cnt_ff <= 6'h00;
               end
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // register writes
   // ----------------------------------------------------------------
   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         for (i = 0; i < 2; i = i + 1)
         begin
            pd_reg_ff[i] <= `MDLOS_RST_PD;
            eq_ff[i] <= `MDLOS_RST_EQ;
            pre_ff[i] <= `MDLOS_RST_PRE;
            post_ff[i] <= `MDLOS_RST_POST;
            losen_ff[i] <= `MDLOS_RST_LOSEN;
         end
         for (i = 0; i < EXT_DEPTH; i = i + 1)
         begin
            ext_ff[i] <= `MDLOS_RST_EXT;
         end
         ptr_ff <= `MDLOS_RST_PTR;
      end
      else if (wr_go)
      begin
         case (wr_reg)
            `MDLOS_REG_CTL1:
               pd_reg_ff[wr_chan] <= wr_data[`MDLOS_CTL1_PD_BIT];
            `MDLOS_REG_EQ:
               eq_ff[wr_chan] <= wr_data[`MDLOS_EQ_EN_BIT];
            `MDLOS_REG_DEEMPH:
            begin
               pre_ff[wr_chan] <=
                  wr_data[`MDLOS_PRE_MSB:`MDLOS_PRE_LSB];
               post_ff[wr_chan] <=
                  wr_data[`MDLOS_POST_MSB:`MDLOS_POST_LSB];
            end
            `MDLOS_REG_LOSEN:
               losen_ff[wr_chan] <= wr_data[`MDLOS_LOSEN_MSB:0];
            `MDLOS_REG_IND_ADDR:
               ptr_ff <= wr_data;
            `MDLOS_REG_IND_DATA:
               if (ext_hit)
               begin
                  ext_ff[ext_idx] <= wr_data;
               end
            default:
               ptr_ff <= ptr_ff;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // output flops
   // ----------------------------------------------------------------
   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         los_ff <= 2'b00;
         pd_ff <= 2'b00;
         eq_out_ff <= 2'b00;
         pre_a_ff <= `MDLOS_RST_PRE;
         post_a_ff <= `MDLOS_RST_POST;
         pre_b_ff <= `MDLOS_RST_PRE;
         post_b_ff <= `MDLOS_RST_POST;
      end
      else
      begin
         los_ff[0] <= los_fn(losen_ff[0], src_a);
         los_ff[1] <= los_fn(losen_ff[1], src_b);
         pd_ff <= pd_now;
         eq_out_ff <= {eq_ff[1], eq_ff[0]};
         pre_a_ff <= pre_ff[0];
         post_a_ff <= post_ff[0];
         pre_b_ff <= pre_ff[1];
         post_b_ff <= post_ff[1];
      end
   end

   assign mdio_out = mdio_out_ff;
   assign mdio_oe = mdio_oe_ff;
   assign chan_a_signal_loss_out = los_ff[0];
   assign chan_b_signal_loss_out = los_ff[1];
   assign powered_down = pd_ff;
   assign ls_tx_hiz = pd_ff;
   assign hs_tx_hiz = pd_ff;
   assign rx_eq_en = eq_out_ff;
   assign deemph_pre_a = pre_a_ff;
   assign deemph_post_a = post_a_ff;
   assign deemph_pre_b = pre_b_ff;
   assign deemph_post_b = post_b_ff;

endmodule // mdlos_top

`default_nettype wire

// *** shared/mdlos_defs.vh ***
// constants for the mdio management and signal-loss block
`ifndef MDLOS_DEFS_VH
`define MDLOS_DEFS_VH

// ----------------------------------------------------------------
// direct register offsets (clause 22 register field)
// ----------------------------------------------------------------
`define MDLOS_REG_CTL1 5'h01
`define MDLOS_REG_EQ 5'h04
`define MDLOS_REG_DEEMPH 5'h05
`define MDLOS_REG_LOSEN 5'h0e
`define MDLOS_REG_STAT 5'h0f
`define MDLOS_REG_IND_ADDR 5'h1e
`define MDLOS_REG_IND_DATA 5'h1f

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define MDLOS_CTL1_PD_BIT 15
`define MDLOS_EQ_EN_BIT 0
`define MDLOS_PRE_MSB 7
`define MDLOS_PRE_LSB 4
`define MDLOS_POST_MSB 12
`define MDLOS_POST_LSB 8
`define MDLOS_LOSEN_MSB 4
`define MDLOS_EN_SYNC 0
`define MDLOS_EN_PLL 1
`define MDLOS_EN_DEC 2
`define MDLOS_EN_AGC 3
`define MDLOS_EN_AZD 4

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define MDLOS_RST_PD 1'b0
`define MDLOS_RST_EQ 1'b1
`define MDLOS_RST_PRE 4'h0
`define MDLOS_RST_POST 5'h00
`define MDLOS_RST_LOSEN 5'h00
`define MDLOS_RST_PTR 16'h0000
`define MDLOS_RST_EXT 16'h0000

// ----------------------------------------------------------------
// frame and extended space
// ----------------------------------------------------------------
`define MDLOS_PRE_BITS 6'h20
`define MDLOS_OP_READ 2'b10
`define MDLOS_OP_WRITE 2'b01
`define MDLOS_EXT_BASE 16'h8000

`endif

// *** verilog/mdlos_sync.v ***
// two-flop synchroniser for a vector of unrelated level inputs
`timescale 1ns/1ps
`default_nettype none

module mdlos_sync #(
   parameter WIDTH = 1
) (
   // clock and reset
   input wire clk,
   input wire resetn,
   // levels
   input wire [WIDTH-1:0] async_in,
   output wire [WIDTH-1:0] sync_out
);

   reg [WIDTH-1:0] meta_ff;
   reg [WIDTH-1:0] sync_ff;

   // each bit is a level; a multi-bit value is only safe while static
   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         meta_ff <= {WIDTH{1'b0}};
         sync_ff <= {WIDTH{1'b0}};
      end
      else
      begin
         meta_ff <= async_in;
         sync_ff <= meta_ff;
      end
   end

   assign sync_out = sync_ff;

endmodule // mdlos_sync

`default_nettype wire

// *** tb/mdlos_properties.sv ***
// concurrent checks on the ports of mdlos_top
`timescale 1ns/1ps
`default_nettype none

module mdlos_properties (
   // clock and reset
   input wire clk,
   input wire resetn,
   // management link
   input wire mdc,
   input wire mdio_out,
   input wire mdio_oe,
   // power down
   input wire chan_a_powerdown_n,
   input wire chan_b_powerdown_n,
   // status sources
   input wire a_raw_los,
   input wire a_sync_lost,
   input wire a_ls_pll_unlock,
   input wire a_hs_pll_unlock,
   input wire a_decode_err,
   input wire a_gain_ctrl_locked,
   input wire a_autozero_cal_done,
   input wire b_raw_los,
   // outputs
   input wire chan_a_signal_loss_out,
   input wire chan_b_signal_loss_out,
   input wire [1:0] powered_down,
   input wire [1:0] ls_tx_hiz,
   input wire [1:0] hs_tx_hiz,
   input wire [1:0] rx_eq_en
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);

   // ------
   // mdc rises counted while the block drives the wire
   // ------
   logic mdc_ff;
   logic [4:0] rise_cnt_ff;
   always @(posedge clk or negedge resetn)
      if (!resetn)
      begin
         mdc_ff <= 1'b0;
         rise_cnt_ff <= 5'h00;
      end
      else
      begin
         mdc_ff <= mdc;
         if (!mdio_oe)
            rise_cnt_ff <= 5'h00;
         else if (mdc && !mdc_ff)
            rise_cnt_ff <= rise_cnt_ff + 5'h01;
      end

   sequence s_pin_a_low;
      !chan_a_powerdown_n [*4];
   endsequence
   sequence s_pin_b_low;
      !chan_b_powerdown_n [*4];
   endsequence
   sequence s_a_healthy;
      (!a_raw_los && !a_sync_lost && !a_ls_pll_unlock && !a_hs_pll_unlock
       && !a_decode_err && a_gain_ctrl_locked && a_autozero_cal_done) [*4];
   endsequence

   a_serdes_hiz: assert property ((ls_tx_hiz == powered_down)
      && (hs_tx_hiz == powered_down))
      else $error("serializer float differs from power down");
   a_pin_down_a: assert property (s_pin_a_low |-> powered_down[0])
      else $error("pin a low but channel a not powered down");
   a_pin_down_b: assert property (s_pin_b_low |-> powered_down[1])
      else $error("pin b low but channel b not powered down");
   a_raw_loss_a: assert property (
      a_raw_los [*4] |-> chan_a_signal_loss_out)
      else $error("raw loss a not on output");
   a_raw_loss_b: assert property (
      b_raw_los [*4] |-> chan_b_signal_loss_out)
      else $error("raw loss b not on output");
   a_healthy_quiet: assert property (
      s_a_healthy |-> !chan_a_signal_loss_out)
      else $error("loss output a high while healthy");
   a_turnaround_low: assert property ($rose(mdio_oe) |-> !mdio_out)
      else $error("turnaround bit not driven low");
   a_drive_span: assert property (
      $fell(mdio_oe) |-> rise_cnt_ff == 5'h11)
      else $error("read drive span not seventeen bits");
   a_eq_reset_on: assert property (
      $rose(resetn) |=> rx_eq_en == 2'b11)
      else $error("equalizer enable not set after reset");
   a_pd_reset_low: assert property (
      $rose(resetn) |=> (powered_down == 2'b00) [*2])
      else $error("power down asserted right after reset");
endmodule // mdlos_properties

bind mdlos_top mdlos_properties i_mdlos_properties (
   .clk, .resetn, .mdc, .mdio_out, .mdio_oe,
   .chan_a_powerdown_n, .chan_b_powerdown_n,
   .a_raw_los, .a_sync_lost, .a_ls_pll_unlock, .a_hs_pll_unlock,
   .a_decode_err, .a_gain_ctrl_locked, .a_autozero_cal_done, .b_raw_los,
   .chan_a_signal_loss_out, .chan_b_signal_loss_out,
   .powered_down, .ls_tx_hiz, .hs_tx_hiz, .rx_eq_en
);

`default_nettype wire

// *** tb/mdlos_mdio_ctrl.sv ***
// station management controller model driving mdc and mdio
`timescale 1ns/1ps
`default_nettype none

module mdlos_mdio_ctrl (
   // link to the block
   output var logic mdc,
   output wire logic mdio_in,
   input wire logic mdio_out,
   input wire logic mdio_oe
);
   logic drv;
   logic bitv;
   // pull-up: a released wire reads high
   assign mdio_in = mdio_oe ? mdio_out : (drv ? bitv : 1'b1);
   initial
   begin
      mdc = 1'b0;
      drv = 1'b0;
      bitv = 1'b1;
   end
   // mdc stands low between frames; offset keeps edges off clk edges
   task automatic xfer(input logic [1:0] op, input logic [4:0] phy,
      input logic [4:0] ra, input logic [15:0] wd, output logic [15:0] rd);
      logic [63:0] f;
      f = {32'hffff_ffff, 2'b01, op, phy, ra, 2'b10, wd};
      rd = 16'h0000;
      #20;
      for (int i = 63; i >= 0; i--)
      begin
         drv = (op != 2'b10) || (i > 17);
         bitv = f[i];
         #400 mdc = 1'b1;
         if (i < 16)
            rd = {rd[14:0], mdio_in};
         #400 mdc = 1'b0;
      end
      drv = 1'b0;
   endtask
endmodule // mdlos_mdio_ctrl

`default_nettype wire

// *** tb/test_mdio_mgmt_los_status.sv ***
// self-checking bench for mdlos_top
`timescale 1ns/1ps
`default_nettype none
`include "mdlos_defs.vh"

module test_mdio_mgmt_los_status;
   localparam logic [3:0] STRAPS = 4'h5;
   localparam logic [6:0] OK = 7'h60;
   logic clk, resetn, mdc, mdio_in, mdio_out, mdio_oe, pd_a_n, pd_b_n;
   logic los_a, los_b;
   logic [1:0] pdn, lhz, hhz, eqen;
   logic [3:0] pre_a, pre_b;
   logic [4:0] post_a, post_b;
   logic [6:0] sa, sb;
   logic [15:0] rv;
   int fails = 0, check_count = 0, cyc = 0, oe_cyc = 0, k;

   mdlos_top i_mdlos_top (
      .clk, .resetn, .mdc, .mdio_in, .mdio_out, .mdio_oe,
      .port_addr_straps(STRAPS),
      .chan_a_powerdown_n(pd_a_n), .chan_b_powerdown_n(pd_b_n),
      .a_raw_los(sa[0]), .a_sync_lost(sa[1]), .a_ls_pll_unlock(sa[2]),
      .a_hs_pll_unlock(sa[3]), .a_decode_err(sa[4]),
      .a_gain_ctrl_locked(sa[5]), .a_autozero_cal_done(sa[6]),
      .b_raw_los(sb[0]), .b_sync_lost(sb[1]), .b_ls_pll_unlock(sb[2]),
      .b_hs_pll_unlock(sb[3]), .b_decode_err(sb[4]),
      .b_gain_ctrl_locked(sb[5]), .b_autozero_cal_done(sb[6]),
      .chan_a_signal_loss_out(los_a), .chan_b_signal_loss_out(los_b),
      .powered_down(pdn), .ls_tx_hiz(lhz), .hs_tx_hiz(hhz),
      .rx_eq_en(eqen), .deemph_pre_a(pre_a), .deemph_post_a(post_a),
      .deemph_pre_b(pre_b), .deemph_post_b(post_b)
   );
   mdlos_mdio_ctrl i_mdlos_mdio_ctrl (.mdc, .mdio_in, .mdio_out, .mdio_oe);

   // ------
   // helpers
   // ------
   task print_verdict;
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         fails++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic ch, input logic [4:0] ra,
      input logic [15:0] d);
      logic [15:0] x;
      i_mdlos_mdio_ctrl.xfer(`MDLOS_OP_WRITE, {STRAPS, ch}, ra, d, x);
      repeat (8) @(posedge clk);
   endtask
   task automatic rd(input logic ch, input logic [4:0] ra,
      output logic [15:0] d);
      i_mdlos_mdio_ctrl.xfer(`MDLOS_OP_READ, {STRAPS, ch}, ra, 16'h0000, d);
      repeat (8) @(posedge clk);
   endtask
   task automatic settle_src(input logic [6:0] a, input logic [6:0] b);
      @(posedge clk);
      sa <= a;
      sb <= b;
      repeat (6) @(posedge clk);
   endtask

   // ------
   // scenarios
   // ------
   task t_reset_eq;
      chk({14'h0, eqen}, 16'h0003);
      chk({3'h0, post_a, pre_a, 4'h0}, 16'h0000);
      rd(0, `MDLOS_REG_LOSEN, rv);
      chk(rv, 16'h0000);
      wr(0, `MDLOS_REG_EQ, 16'h0000);
      chk({14'h0, eqen}, 16'h0002);
      rd(1, `MDLOS_REG_EQ, rv);
      chk(rv, 16'h0001);
   endtask
   task t_deemph;
      wr(1, `MDLOS_REG_DEEMPH, 16'h1a50);
      chk({3'h0, post_b, pre_b, 4'h0}, 16'h1a50);
      chk({3'h0, post_a, pre_a, 4'h0}, 16'h0000);
      rd(1, `MDLOS_REG_DEEMPH, rv);
      chk(rv, 16'h1a50);
   endtask
   task t_los;
      settle_src(7'h1e, 7'h1e);
      chk({14'h0, los_b, los_a}, 16'h0000);
      for (int j = 1; j < 7; j++)
      begin
         k = j - 1 - (j > 2);
         wr(0, `MDLOS_REG_LOSEN, 16'h0001 << k);
         wr(1, `MDLOS_REG_LOSEN, 16'h001f ^ (16'h0001 << k));
         settle_src(OK ^ (7'h01 << j), OK ^ (7'h01 << j));
         chk({14'h0, los_b, los_a}, 16'h0001);
         settle_src(OK, OK);
         chk({14'h0, los_b, los_a}, 16'h0000);
      end
      settle_src(OK, OK | 7'h01);
      chk({14'h0, los_b, los_a}, 16'h0002);
      settle_src(OK | 7'h01, OK);
      chk({14'h0, los_b, los_a}, 16'h0001);
      rd(0, `MDLOS_REG_STAT, rv);
      chk(rv, 16'h0061);
      wr(0, `MDLOS_REG_STAT, 16'h0000);
      rd(1, `MDLOS_REG_STAT, rv);
      chk(rv, 16'h0060);
      rd(0, `MDLOS_REG_STAT, rv);
      chk(rv, 16'h0061);
      settle_src(OK, OK);
   endtask
   task t_pd;
      @(posedge clk);
      pd_a_n <= 1'b0;
      repeat (6) @(posedge clk);
      chk({10'h0, hhz, lhz, pdn}, 16'h0015);
      pd_a_n <= 1'b1;
      pd_b_n <= 1'b0;
      repeat (6) @(posedge clk);
      chk({10'h0, hhz, lhz, pdn}, 16'h002a);
      pd_b_n <= 1'b1;
      wr(0, `MDLOS_REG_CTL1, 16'h8000);
      wr(1, `MDLOS_REG_CTL1, 16'h8000);
      chk({10'h0, hhz, lhz, pdn}, 16'h003f);
      rd(1, `MDLOS_REG_DEEMPH, rv);
      chk(rv, 16'h1a50);
      wr(0, `MDLOS_REG_CTL1, 16'h0000);
      wr(1, `MDLOS_REG_CTL1, 16'h0000);
      chk({14'h0, pdn}, 16'h0000);
   endtask
   task t_addr;
      k = oe_cyc;
      i_mdlos_mdio_ctrl.xfer(`MDLOS_OP_WRITE, {STRAPS ^ 4'h1, 1'b1},
         `MDLOS_REG_DEEMPH, 16'h0000, rv);
      i_mdlos_mdio_ctrl.xfer(`MDLOS_OP_READ, {STRAPS ^ 4'h1, 1'b1},
         `MDLOS_REG_DEEMPH, 16'h0000, rv);
      repeat (8) @(posedge clk);
      chk(rv, 16'hffff);
      chk(16'(oe_cyc - k), 16'h0000);
      rd(1, `MDLOS_REG_DEEMPH, rv);
      chk(rv, 16'h1a50);
      wr(1, 5'h10, 16'hffff);
      rd(1, 5'h10, rv);
      chk(rv, 16'h0000);
   endtask
   task t_indirect;
      wr(0, `MDLOS_REG_IND_ADDR, 16'h8002);
      wr(0, `MDLOS_REG_IND_DATA, 16'hbeef);
      wr(1, `MDLOS_REG_IND_ADDR, 16'h8001);
      wr(0, `MDLOS_REG_IND_DATA, 16'h1234);
      wr(0, `MDLOS_REG_IND_ADDR, 16'h8002);
      rd(1, `MDLOS_REG_IND_DATA, rv);
      chk(rv, 16'hbeef);
      rd(0, `MDLOS_REG_IND_DATA, rv);
      chk(rv, 16'hbeef);
      rd(0, `MDLOS_REG_IND_ADDR, rv);
      chk(rv, 16'h8002);
      wr(0, `MDLOS_REG_IND_ADDR, 16'h7fff);
      wr(0, `MDLOS_REG_IND_DATA, 16'h5555);
      rd(0, `MDLOS_REG_IND_DATA, rv);
      chk(rv, 16'h0000);
      wr(0, `MDLOS_REG_IND_ADDR, 16'h8003);
      rd(0, `MDLOS_REG_IND_DATA, rv);
      chk(rv, 16'h0000);
      wr(0, `MDLOS_REG_IND_ADDR, 16'h8001);
      rd(0, `MDLOS_REG_IND_DATA, rv);
      chk(rv, 16'h1234);
   endtask

   // ------
   // clock, watchdog and main sequence
   // ------
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (mdio_oe === 1'b1)
         oe_cyc <= oe_cyc + 1;
      if (cyc == 50000)
      begin
         fails++;
         print_verdict;
      end
   end
   initial
   begin
      resetn = 1'b0;
      pd_a_n = 1'b1;
      pd_b_n = 1'b1;
      sa = OK;
      sb = OK;
      repeat (8) @(posedge clk);
      resetn <= 1'b1;
      repeat (4) @(posedge clk);
      t_reset_eq;
      t_deemph;
      t_los;
      t_pd;
      t_addr;
      t_indirect;
      print_verdict;
   end
endmodule // test_mdio_mgmt_los_status

`default_nettype wire
